// *** pkg/scb_pkg.sv ***
// Constants for the control-word decoder: offsets, fields, codes.
// Assumes a 32-bit APB slave with byte addresses of 8 bits.
package scb_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] CMD_OFF    = 8'h00;
    localparam logic [7:0] PTR_OFF    = 8'h04;
    localparam logic [7:0] STAT_OFF   = 8'h08;
    localparam logic [7:0] RUBASE_OFF = 8'h0c;
    localparam logic [7:0] CUBASE_OFF = 8'h10;
    localparam logic [7:0] DUMP_OFF   = 8'h14;
    localparam logic [7:0] RFD_OFF    = 8'h18;
    localparam logic [7:0] CB_OFF     = 8'h1c;
    localparam logic [7:0] HDS_OFF    = 8'h20;
    localparam logic [7:0] RBD_OFF    = 8'h24;
    // ==========================================================
    // Field layout of the command word
    localparam int CUC_LSB = 20;
    localparam int CUC_W   = 4;
    localparam int RUC_LSB = 16;
    localparam int RUC_W   = 3;
    localparam int HDS_W   = 14;
    localparam logic [31:0] RST_WORD = 32'h0;
    // ==========================================================
    // Receive command codes
    localparam logic [2:0] RUC_NOP      = 3'h0;
    localparam logic [2:0] RUC_START    = 3'h1;
    localparam logic [2:0] RUC_RESUME   = 3'h2;
    localparam logic [2:0] RUC_REDIRECT = 3'h3;
    localparam logic [2:0] RUC_ABORT    = 3'h4;
    localparam logic [2:0] RUC_LOAD_HDS = 3'h5;
    localparam logic [2:0] RUC_LOAD_BAS = 3'h6;
    // ==========================================================
    // Command-unit command codes
    localparam logic [3:0] CUC_NOP      = 4'h0;
    localparam logic [3:0] CUC_START    = 4'h1;
    localparam logic [3:0] CUC_RESUME   = 4'h2;
    localparam logic [3:0] CUC_HPQ_ST   = 4'h3;
    localparam logic [3:0] CUC_LD_DUMP  = 4'h4;
    localparam logic [3:0] CUC_DUMP     = 4'h5;
    localparam logic [3:0] CUC_LOAD_BAS = 4'h6;
    localparam logic [3:0] CUC_DUMP_RST = 4'h7;
    localparam logic [3:0] CUC_STAT_RES = 4'ha;
    localparam logic [3:0] CUC_HPQ_RES  = 4'hb;
    // ==========================================================
    // Status bit positions
    localparam int ST_IDLE  = 0;
    localparam int ST_FETCH = 1;
    localparam int ST_READY = 2;
    localparam int ST_SUSP  = 3;
    localparam int ST_HDS   = 4;
    localparam int ST_CUIDL = 5;

    typedef enum logic [1:0] {
        RU_IDLE,
        RU_FETCH,
        RU_READY,
        RU_SUSP
    } scb_ru_state_t;
endpackage

// *** design/scb_rst_sync.sv ***
// Reset release synchroniser.
// Assumes an asynchronous active-low reset from outside the clock domain.
`timescale 1ns/1ps
module scb_rst_sync (
    input  wire logic clk,
    input  wire logic resetn,
    output logic      rstnSync
);
    typedef struct packed {
        logic [1:0] sh;
    } scb_rs_state_t;

    scb_rs_state_t st_q;
    scb_rs_state_t st_d;

    // ==========================================================
    // Two stages, assert at once, release after two edges
    always_comb begin
        st_d    = st_q;
        st_d.sh = {st_q.sh[0], 1'b1};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rstnSync = st_q.sh[1];
endmodule

// *** design/scb_ptr_add.sv ***
// Base plus offset for pointer relocation.
// Assumes offsets wrap modulo two to the width, as addresses do.
`timescale 1ns/1ps
module scb_ptr_add #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] base,
    input  wire logic [W-1:0] offset,
    output logic      [W-1:0] sum
);
    // Elaboration guard; a zero width leaves no adder to build
    if (W < 1) begin : g_width_check
        $error("scb_ptr_add: width must be positive");
    end

    // ==========================================================
    // Carry out dropped on purpose: addresses wrap
    assign sum = W'(base + offset);
endmodule

// *** design/scb_ctl_decoder.sv ***
// Control-word decoder: receive and command-unit command fields and
// the general pointer, reached over APB.
// Assumes unit engines on the same clock give fetchDone, ruSuspendEvt
// and cuIdle, and take the one-cycle command pulses.
//
// Summary of operation
// - Receive code 000 does nothing, receive state kept.
// - Code 001 enables receive unit and prefetches first frame descriptor.
// - Code 010 resumes reception, only while receive unit is suspended.
// - Code 011 redirects receive DMA to buffer chain at base plus pointer.
// - Code 100 stops the receive unit immediately.
// - After code 101 header-size mode holds until reset.
// - Header size is pointer bits 13:0; host zeroes upper bits.
// - Code 110 copies pointer held before the command into receive base.
// - General pointer is 32 bits, meaning set by the command code.
// - Receive start address is pointer plus receive base.
// - Command start code 1 locates first block at pointer plus base.
// - Priority queue start code 3 adds pointer to command base.
// - Code 4 latches pointer as absolute counter dump address.
// - Code 6 loads pointer into the command base register.
// - Command-unit field is bits 23:20 of the command word.
// - Command resume is ignored while the command unit is idle.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module scb_ctl_decoder
    import scb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        fetchDone,
    input  wire logic        ruSuspendEvt,
    input  wire logic        cuIdle,
    output logic             ruFetchReq,
    output logic             ruResume,
    output logic             ruAbort,
    output logic             ruRedirect,
    output logic             cuStart,
    output logic             cuHpqStart,
    output logic             cuResume,
    output logic             cuStaticResume,
    output logic             cuHpqResume,
    output logic             cntDump,
    output logic             cntDumpReset,
    output logic             hdsMode,
    output logic      [13:0] hdsSize,
    output logic      [31:0] rfdAddr,
    output logic      [31:0] cbAddr,
    output logic      [31:0] rbdAddr,
    output logic      [31:0] dumpAddr
);
    import scb_pkg::*;

    typedef struct packed {
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic [31:0]       gptr;
        logic [31:0]       ruBase;
        logic [31:0]       cuBase;
        logic [31:0]       dumpAddr;
        logic [31:0]       rfdAddr;
        logic [31:0]       cbAddr;
        logic [31:0]       rbdAddr;
        logic [HDS_W-1:0]  header_data_size;
        logic              hdsLock;
        scb_ru_state_t     ruSt;
        logic              fetchReq;
        logic              ruResumeP;
        logic              ruAbortP;
        logic              ruRedirP;
        logic              cuStartP;
        logic              cuHpqP;
        logic              cuResumeP;
        logic              cuStaticP;
        logic              cuHpqResP;
        logic              dumpP;
        logic              dumpRstP;
    } scb_state_t;

    scb_state_t  st_q;
    scb_state_t  st_d;
    logic        rstn;
    logic [31:0] ruSum;
    logic [31:0] cuSum;
    logic        access;
    logic        wrDone;
    logic        cmdWr;
    logic [2:0]  ruCode;
    logic [3:0]  cuCode;
    logic        mapped;
    logic [31:0] status;

    // ==========================================================
    // Reset and pointer adders
    scb_rst_sync u_rst (
        .clk      (clk),
        .resetn   (resetn),
        .rstnSync (rstn)
    );

    scb_ptr_add #(.W(32)) u_ru_add (
        .base   (st_q.ruBase),
        .offset (st_q.gptr),
        .sum    (ruSum)
    );

    scb_ptr_add #(.W(32)) u_cu_add (
        .base   (st_q.cuBase),
        .offset (st_q.gptr),
        .sum    (cuSum)
    );

    // ==========================================================
    // Bus decode
    assign access = psel && penable;
    assign wrDone = access && st_q.pready && pwrite;
    assign cmdWr  = wrDone && (paddr == CMD_OFF);
    assign cuCode = pwdata[CUC_LSB +: CUC_W];
    assign ruCode = pwdata[RUC_LSB +: RUC_W];

    always_comb begin
        unique case (paddr)
            CMD_OFF, PTR_OFF, STAT_OFF, RUBASE_OFF, CUBASE_OFF,
            DUMP_OFF, RFD_OFF, CB_OFF, HDS_OFF, RBD_OFF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        status            = '0;
        status[ST_IDLE]   = (st_q.ruSt == RU_IDLE);
        status[ST_FETCH]  = (st_q.ruSt == RU_FETCH);
        status[ST_READY]  = (st_q.ruSt == RU_READY);
        status[ST_SUSP]   = (st_q.ruSt == RU_SUSP);
        status[ST_HDS]    = st_q.hdsLock;
        status[ST_CUIDL]  = cuIdle;
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_d           = st_q;
        st_d.ruResumeP = 1'b0;
        st_d.ruAbortP  = 1'b0;
        st_d.ruRedirP  = 1'b0;
        st_d.cuStartP  = 1'b0;
        st_d.cuHpqP    = 1'b0;
        st_d.cuResumeP = 1'b0;
        st_d.cuStaticP = 1'b0;
        st_d.cuHpqResP = 1'b0;
        st_d.dumpP     = 1'b0;
        st_d.dumpRstP  = 1'b0;
        st_d.pslverr   = 1'b0;
        // Two-cycle access gives time to register read data
        st_d.pready    = access && !st_q.pready;
        if (access && !st_q.pready) begin
            st_d.pslverr = !mapped;
            st_d.prdata  = '0;
            if (!pwrite) begin
                unique case (paddr)
                    PTR_OFF:    st_d.prdata = st_q.gptr;
                    STAT_OFF:   st_d.prdata = status;
                    RUBASE_OFF: st_d.prdata = st_q.ruBase;
                    CUBASE_OFF: st_d.prdata = st_q.cuBase;
                    DUMP_OFF:   st_d.prdata = st_q.dumpAddr;
                    RFD_OFF:    st_d.prdata = st_q.rfdAddr;
                    CB_OFF:     st_d.prdata = st_q.cbAddr;
                    HDS_OFF:    st_d.prdata = {18'h0, st_q.header_data_size};
                    RBD_OFF:    st_d.prdata = st_q.rbdAddr;
                    default:    st_d.prdata = '0;
                endcase
            end
        end
        if (wrDone && paddr == PTR_OFF) begin
            st_d.gptr = pwdata;
        end

        // Engine feedback; a receive start or abort command in the same cycle overrides it
        if (st_q.ruSt == RU_FETCH && fetchDone) begin
            st_d.ruSt = RU_READY;
        end
        if (st_q.ruSt == RU_READY && ruSuspendEvt) begin
            st_d.ruSt = RU_SUSP;
        end

        if (cmdWr) begin
            // undefined receive codes fall to default
            unique case (ruCode)
                RUC_NOP: begin
                end
                RUC_START: begin
                    st_d.ruSt    = RU_FETCH;
                    st_d.rfdAddr = ruSum;
                end
                RUC_RESUME: begin
                    if (st_q.ruSt == RU_SUSP) begin
                        st_d.ruSt      = RU_READY;
                        st_d.ruResumeP = 1'b1;
                    end
                end
                RUC_REDIRECT: begin
                    st_d.ruRedirP = 1'b1;
                    st_d.rbdAddr  = ruSum;
                end
                RUC_ABORT: begin
                    st_d.ruSt     = RU_IDLE;
                    st_d.ruAbortP = 1'b1;
                end
                RUC_LOAD_HDS: begin
                    st_d.header_data_size     = st_q.gptr[HDS_W-1:0];
                    st_d.hdsLock = 1'b1;
                end
                RUC_LOAD_BAS: begin
                    st_d.ruBase = st_q.gptr;
                end
                default: begin
                end
            endcase
            // don't-care codes never read the pointer
            unique case (cuCode)
                CUC_NOP: begin
                end
                CUC_START: begin
                    st_d.cuStartP = 1'b1;
                    st_d.cbAddr   = cuSum;
                end
                CUC_RESUME: begin
                    st_d.cuResumeP = !cuIdle;
                end
                CUC_HPQ_ST: begin
                    st_d.cuHpqP = 1'b1;
                    st_d.cbAddr = cuSum;
                end
                CUC_LD_DUMP: begin
                    st_d.dumpAddr = st_q.gptr;
                end
                CUC_DUMP: begin
                    st_d.dumpP = 1'b1;
                end
                CUC_LOAD_BAS: begin
                    st_d.cuBase = st_q.gptr;
                end
                CUC_DUMP_RST: begin
                    st_d.dumpRstP = 1'b1;
                end
                CUC_STAT_RES: begin
                    st_d.cuStaticP = !cuIdle;
                end
                CUC_HPQ_RES: begin
                    st_d.cuHpqResP = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // Own flop so the pin carries no decode glitch
        st_d.fetchReq = (st_d.ruSt == RU_FETCH);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q      <= '0;
            st_q.ruSt <= RU_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs, all from flops
    assign pready         = st_q.pready;
    assign prdata         = st_q.prdata;
    assign pslverr        = st_q.pslverr;
    assign ruFetchReq     = st_q.fetchReq;
    assign ruResume       = st_q.ruResumeP;
    assign ruAbort        = st_q.ruAbortP;
    assign ruRedirect     = st_q.ruRedirP;
    assign cuStart        = st_q.cuStartP;
    assign cuHpqStart     = st_q.cuHpqP;
    assign cuResume       = st_q.cuResumeP;
    assign cuStaticResume = st_q.cuStaticP;
    assign cuHpqResume    = st_q.cuHpqResP;
    assign cntDump        = st_q.dumpP;
    assign cntDumpReset   = st_q.dumpRstP;
    assign hdsMode        = st_q.hdsLock;
    assign hdsSize        = st_q.header_data_size;
    assign rfdAddr        = st_q.rfdAddr;
    assign cbAddr         = st_q.cbAddr;
    assign rbdAddr        = st_q.rbdAddr;
    assign dumpAddr       = st_q.dumpAddr;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    nop_keeps_a: assert property (cmdWr && ruCode == RUC_NOP
        && !fetchDone && !ruSuspendEvt |=> $stable(st_q.ruSt))
        else $error("receive no-op changed state");
    start_fetch_a: assert property (cmdWr && ruCode == RUC_START
        |=> ruFetchReq && rfdAddr == $past(ruSum))
        else $error("receive start did not prefetch");
    resume_susp_a: assert property (ruResume
        |-> $past(st_q.ruSt) == RU_SUSP)
        else $error("resume outside suspended state");
    redirect_a: assert property (cmdWr && ruCode == RUC_REDIRECT
        |=> ruRedirect ##1 !ruRedirect)
        else $error("redirect pulse wrong");
    abort_stop_a: assert property (cmdWr && ruCode == RUC_ABORT
        |=> ruAbort && !ruFetchReq && status[ST_IDLE])
        else $error("abort did not stop receive unit");
    hds_sticky_a: assert property ($rose(hdsMode)
        |=> hdsMode [*8])
        else $error("header mode dropped");
    hds_low_a: assert property (cmdWr && ruCode == RUC_LOAD_HDS
        |=> hdsSize == $past(st_q.gptr[HDS_W-1:0]))
        else $error("header size not from low bits");
    rubase_a: assert property (cmdWr && ruCode == RUC_LOAD_BAS
        |=> st_q.ruBase == $past(st_q.gptr))
        else $error("receive base not loaded");
    cbaddr_a: assert property (cmdWr && cuCode == CUC_START
        |=> cuStart && cbAddr == $past(st_q.cuBase + st_q.gptr))
        else $error("command start address wrong");
    dump_abs_a: assert property (cmdWr && cuCode == CUC_LD_DUMP
        |=> dumpAddr == $past(st_q.gptr))
        else $error("dump address not absolute");
    idle_resume_a: assert property (cmdWr && cuCode == CUC_RESUME
        && cuIdle |=> !cuResume)
        else $error("resume accepted while idle");

    start_cov: cover property (cmdWr && ruCode == RUC_START
        ##[1:30] fetchDone);
    susp_cov: cover property (ruSuspendEvt ##[1:60] ruResume);
    hpq_cov: cover property (cuHpqStart);
    err_cov: cover property (pslverr);
endmodule

// *** test/scb_engine_model.sv ***
// Behavioural model of the unit engines beside the decoder.
// Assumes the decoder's clock; the bench steers latency and events.
`timescale 1ns/1ps
module scb_engine_model #(
    parameter int SLOW_LAT = 20
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ruFetchReq,
    input  wire logic slowFetch,
    input  wire logic suspendReq,
    input  wire logic idleReq,
    output logic      fetchDone,
    output logic      ruSuspendEvt,
    output logic      cuIdle
);
    logic [7:0] waitCnt;

    // ==========================================================
    // Engine answers
    // prefetch answered, prompt or slow
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitCnt      <= 8'h00;
            fetchDone    <= 1'b0;
            ruSuspendEvt <= 1'b0;
            cuIdle       <= 1'b1;
        end else begin
            fetchDone    <= 1'b0;
            ruSuspendEvt <= suspendReq;
            cuIdle       <= idleReq;
            // Done pulse once; request drops the cycle after
            if (ruFetchReq && !fetchDone) begin
                if (waitCnt >= (slowFetch ? 8'(SLOW_LAT - 1) : 8'h00)) begin
                    fetchDone <= 1'b1;
                    waitCnt   <= 8'h00;
                end else begin
                    waitCnt <= waitCnt + 8'h01;
                end
            end else begin
                waitCnt <= 8'h00;
            end
        end
    end
endmodule

// *** test/scb_receive_command_pointer_decoder_tb_top.sv ***
// Self-checking bench for the control-word decoder.
// Assumes the engine model on the far side and an APB master here.
`timescale 1ns/1ps
module scb_receive_command_pointer_decoder_tb_top;
    import scb_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rfdAddr, cbAddr, rbdAddr, dumpAddr;
    logic        fetchDone, ruSuspendEvt, cuIdle, ruFetchReq, hdsMode;
    logic        ruResume, ruAbort, ruRedirect, cuStart, cuHpqStart;
    logic        cuResume, cuStaticResume, cuHpqResume, cntDump;
    logic        cntDumpReset, slowFetch, suspendReq, idleReq;
    logic [13:0] hdsSize;
    logic [9:0]  pulseVec;
    logic [7:0]  pulseCnt [10] = '{default: 8'h00};
    int          errTotal, checksDone;

    scb_ctl_decoder scb_ctl_decoder_inst (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .fetchDone(fetchDone),
        .ruSuspendEvt(ruSuspendEvt), .cuIdle(cuIdle),
        .ruFetchReq(ruFetchReq), .ruResume(ruResume), .ruAbort(ruAbort),
        .ruRedirect(ruRedirect), .cuStart(cuStart),
        .cuHpqStart(cuHpqStart), .cuResume(cuResume),
        .cuStaticResume(cuStaticResume), .cuHpqResume(cuHpqResume),
        .cntDump(cntDump), .cntDumpReset(cntDumpReset),
        .hdsMode(hdsMode), .hdsSize(hdsSize), .rfdAddr(rfdAddr),
        .cbAddr(cbAddr), .rbdAddr(rbdAddr), .dumpAddr(dumpAddr));

    scb_engine_model scb_engine_model_inst (.clk(clk), .resetn(resetn),
        .ruFetchReq(ruFetchReq), .slowFetch(slowFetch),
        .suspendReq(suspendReq), .idleReq(idleReq),
        .fetchDone(fetchDone), .ruSuspendEvt(ruSuspendEvt),
        .cuIdle(cuIdle));

    always #4 clk = ~clk;

    // ==========================================================
    // Pulse counting; a two-cycle pulse shows as a count of two
    assign pulseVec = {cntDumpReset, cntDump, cuHpqResume, cuStaticResume,
                       cuResume, cuHpqStart, cuStart, ruRedirect, ruAbort,
                       ruResume};
    always @(posedge clk) begin
        for (int i = 0; i < 10; i++) begin
            pulseCnt[i] <= pulseCnt[i] + 8'(pulseVec[i]);
        end
    end

    // ==========================================================
    // Tasks
    task stopTest();
        if (errTotal == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one edge after release
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, 32'h0);
    endtask

    task cmd(input logic [31:0] ptr, input logic [3:0] cc,
             input logic [2:0] rc, input logic [9:0] exp);
        logic [7:0] snap [10];
        logic [9:0] got;
        // pointer written before the command that uses it
        wr(CMD_OFF + 8'h04, ptr);
        snap = pulseCnt;
        wr(CMD_OFF, {8'h00, cc, 1'b0, rc, 16'h0000});
        repeat (2) @(posedge clk);
        for (int i = 0; i < 10; i++) got[i] = (pulseCnt[i] - snap[i]) == 8'h01;
        check({22'h0, got}, {22'h0, exp});
    endtask

    function automatic logic [9:0] expCu(input logic [3:0] c);
        case (c)
            4'h1:    return 10'h008;
            4'h2:    return 10'h020;
            4'h3:    return 10'h010;
            4'h5:    return 10'h100;
            4'h7:    return 10'h200;
            4'ha:    return 10'h040;
            4'hb:    return 10'h080;
            default: return 10'h000;
        endcase
    endfunction

    // ==========================================================
    // Watchdog; whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        stopTest();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        int          n;
        clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0; slowFetch = 0; suspendReq = 0;
        idleReq = 1; errTotal = 0; checksDone = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk(STAT_OFF, 32'h21);
        rdchk(RUBASE_OFF, 32'h0);
        apb(1'b0, 8'h28, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        wr(PTR_OFF, 32'ha5a5_0f0f);
        rdchk(PTR_OFF, 32'ha5a5_0f0f);
        cmd(32'h0000_1000, 4'h0, 3'h6, 10'h000);
        rdchk(RUBASE_OFF, 32'h0000_1000);
        slowFetch <= 1'b1;
        cmd(32'h20, 4'h0, 3'h1, 10'h000);
        check(rfdAddr, 32'h0000_1020);
        check({31'h0, ruFetchReq}, 32'h1);
        cmd(32'h0, 4'h0, 3'h2, 10'h000);
        n = 0;
        while (ruFetchReq !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        rdchk(STAT_OFF, 32'h24);
        cmd(32'h0, 4'h0, 3'h2, 10'h000);
        suspendReq <= 1'b1;
        @(posedge clk);
        suspendReq <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(STAT_OFF, 32'h28);
        cmd(32'h0, 4'h0, 3'h0, 10'h000);
        cmd(32'h0, 4'h0, 3'h7, 10'h000);
        rdchk(STAT_OFF, 32'h28);
        cmd(32'hffff_ffff, 4'h0, 3'h2, 10'h001);
        cmd(32'h40, 4'h0, 3'h3, 10'h004);
        check(rbdAddr, 32'h0000_1040);
        // header size even, non-zero, upper bits zero
        cmd(32'h0000_0100, 4'h0, 3'h5, 10'h000);
        check({18'h0, hdsSize}, 32'h100);
        cmd(32'h0, 4'h0, 3'h4, 10'h002);
        rdchk(STAT_OFF, 32'h31);
        cmd(32'h0000_2000, 4'h6, 3'h0, 10'h000);
        rdchk(CUBASE_OFF, 32'h0000_2000);
        cmd(32'h10, 4'h1, 3'h0, 10'h008);
        check(cbAddr, 32'h0000_2010);
        cmd(32'h30, 4'h3, 3'h0, 10'h010);
        check(cbAddr, 32'h0000_2030);
        cmd(32'h8000_4000, 4'h4, 3'h0, 10'h000);
        check(dumpAddr, 32'h8000_4000);
        cmd(32'h5555, 4'h2, 3'h0, 10'h000);
        cmd(32'h0, 4'ha, 3'h0, 10'h000);
        check(cbAddr, 32'h0000_2030);
        idleReq <= 1'b0;
        repeat (2) @(posedge clk);
        for (int c = 0; c < 16; c++) cmd(32'h0, 4'(c), 3'h0, expCu(4'(c)));
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        check({31'h0, hdsMode}, 32'h0);
        stopTest();
    end
endmodule
